// [hw/tsi_pkg.sv]
// constants shared by the two-source interrupt unit
package tsi_pkg;
    localparam int TSI_PC_W = 11;
    localparam int TSI_SP_W = 3;
    localparam logic [2:0] TSI_STACK_DEPTH = 3'h4;
    localparam logic [10:0] TSI_PIN_VECTOR = 11'h004;
    localparam logic [10:0] TSI_TIMER_VECTOR = 11'h008;
    localparam int TSI_EDGE_LO_BIT = 6;
    localparam int TSI_EDGE_HI_BIT = 7;
    localparam int TSI_TIMER_RUN_BIT = 4;
    localparam int TSI_PIN_DIR_BIT = 3;
    localparam logic [1:0] TSI_EDGE_OFF = 2'h0;
    localparam logic [1:0] TSI_EDGE_RISE = 2'h1;
    localparam logic [1:0] TSI_EDGE_FALL = 2'h2;
    localparam logic [1:0] TSI_EDGE_BOTH = 2'h3;
    typedef enum logic [1:0] {TSI_SRC_NONE, TSI_SRC_PIN, TSI_SRC_TIMER}
        tsi_src_t;
endpackage : tsi_pkg

// [hw/tsi_pin_edge.sv]
// synchroniser and edge qualifier for the external pin
`timescale 1ns/10ps
module tsi_pin_edge
    import tsi_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_pin,
    input wire logic [1:0] i_edge_sel,
    output logic o_edge
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    wire rise = sync_q & ~prev_q;
    wire fall = ~sync_q & prev_q;
    wire hit = (i_edge_sel == TSI_EDGE_RISE) ? rise :
               (i_edge_sel == TSI_EDGE_FALL) ? fall :
               (i_edge_sel == TSI_EDGE_BOTH) ? (rise | fall) : 1'b0;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            o_edge <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
            o_edge <= hit;
        end
    end

    single_pulse_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (o_edge && !(rise || fall)) |=> !o_edge
    ) else $error("pin edge pulse longer than one cycle");

    edge_off_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_edge_sel == TSI_EDGE_OFF) |=> !o_edge
    ) else $error("pin edge seen while edge select is off");
endmodule : tsi_pin_edge

// [hw/tsi_phase_div.sv]
// divider making the second clock phase enable pulse
`timescale 1ns/10ps
module tsi_phase_div #(
    parameter int DIV = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    output logic o_phase
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_q;
    wire last = (cnt_q == CW'(DIV - 1));

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
            o_phase <= 1'b0;
        end else begin
            cnt_q <= last ? '0 : cnt_q + 1'b1;
            o_phase <= last;
        end
    end
endmodule : tsi_phase_div

// [hw/tsi_irq_unit.sv]
// two-source interrupt unit with pc stack and vectoring
`timescale 1ns/10ps
module tsi_irq_unit
    import tsi_pkg::*;
#(
    parameter int PHASE_DIV = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_pin,
    input wire logic i_timer_ovf,
    input wire logic [7:0] i_misc_control_reg,
    input wire logic [7:0] i_timer_control_reg,
    input wire logic [7:0] i_port_direction_reg,
    input wire logic i_pullhigh_en,
    input wire logic i_global_set,
    input wire logic i_global_clr,
    input wire logic i_pin_en_wr,
    input wire logic i_pin_en_val,
    input wire logic i_timer_en_wr,
    input wire logic i_timer_en_val,
    input wire logic i_pin_flag_clr,
    input wire logic i_timer_flag_clr,
    input wire logic i_pin_flag_set,
    input wire logic i_timer_flag_set,
    input wire logic i_call_push,
    input wire logic i_ret_pop,
    input wire logic i_halted,
    input wire logic [TSI_PC_W-1:0] i_next_pc,
    output logic o_global_irq_enable,
    output logic o_pin_irq_enable,
    output logic o_timer_irq_enable,
    output logic o_pin_irq_flag,
    output logic o_timer_irq_flag,
    output logic o_vector_load,
    output logic [TSI_PC_W-1:0] o_vector_pc,
    output logic o_return_load,
    output logic [TSI_PC_W-1:0] o_return_pc,
    output logic [TSI_SP_W-1:0] o_stack_ptr,
    output logic o_stack_full,
    output logic o_wake,
    output logic o_timer_run,
    output logic o_pullhigh,
    output logic o_pin_is_irq
);
    logic pin_edge;
    logic phase;
    logic ge_q;
    logic pe_q;
    logic te_q;
    logic pf_q;
    logic tf_q;
    logic [TSI_SP_W-1:0] sp_q;
    logic [TSI_PC_W-1:0] stack_q [0:3];
    tsi_src_t win;

    tsi_pin_edge u_edge (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_pin(i_pin),
        .i_edge_sel({i_misc_control_reg[TSI_EDGE_HI_BIT],
                     i_misc_control_reg[TSI_EDGE_LO_BIT]}),
        .o_edge(pin_edge)
    );

    tsi_phase_div #(.DIV(PHASE_DIV)) u_phase (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .o_phase(phase)
    );

    // events set flags whatever the enables say; set wins over clear
    wire pin_set = pin_edge | i_pin_flag_set;
    wire tmr_set = i_timer_ovf | i_timer_flag_set;
    wire full = (sp_q == TSI_STACK_DEPTH);
    wire pin_req = pf_q & pe_q;
    wire tmr_req = tf_q & te_q;
    wire any_req = pin_req | tmr_req;
    wire take = phase & ge_q & ~full & any_req;
    assign win = !take ? TSI_SRC_NONE :
                 pin_req ? TSI_SRC_PIN : TSI_SRC_TIMER;
    wire pop = i_ret_pop & (sp_q != '0) & ~take;
    wire push = i_call_push & ~full & ~take;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ge_q <= 1'b0;
            pe_q <= 1'b0;
            te_q <= 1'b0;
        end else begin
            if (take) ge_q <= 1'b0;
            else if (i_global_set) ge_q <= 1'b1;
            else if (i_global_clr) ge_q <= 1'b0;
            if (i_pin_en_wr) pe_q <= i_pin_en_val;
            if (i_timer_en_wr) te_q <= i_timer_en_val;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pf_q <= 1'b0;
            tf_q <= 1'b0;
        end else begin
            if (pin_set) pf_q <= 1'b1;
            else if ((win == TSI_SRC_PIN) || i_pin_flag_clr)
                pf_q <= 1'b0;
            if (tmr_set) tf_q <= 1'b1;
            else if ((win == TSI_SRC_TIMER) || i_timer_flag_clr)
                tf_q <= 1'b0;
        end
    end

    // hardware stack holds the pc only
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sp_q <= '0;
        end else if (take || push) begin
            sp_q <= sp_q + 1'b1;
        end else if (pop) begin
            sp_q <= sp_q - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (take || push) stack_q[sp_q[1:0]] <= i_next_pc;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_vector_load <= 1'b0;
            o_vector_pc <= '0;
            o_return_load <= 1'b0;
            o_return_pc <= '0;
            o_wake <= 1'b0;
            o_timer_run <= 1'b0;
            o_pullhigh <= 1'b0;
            o_pin_is_irq <= 1'b0;
        end else begin
            o_vector_load <= take;
            if (take) o_vector_pc <= (win == TSI_SRC_PIN) ?
                TSI_PIN_VECTOR : TSI_TIMER_VECTOR;
            o_return_load <= pop;
            if (pop) o_return_pc <= stack_q[2'(sp_q - 1'b1)];
            o_wake <= i_halted & (pin_set | tmr_set);
            o_timer_run <= i_timer_control_reg[TSI_TIMER_RUN_BIT];
            o_pullhigh <= i_pullhigh_en;
            o_pin_is_irq <= pe_q & i_port_direction_reg[TSI_PIN_DIR_BIT] &
                ({i_misc_control_reg[TSI_EDGE_HI_BIT],
                  i_misc_control_reg[TSI_EDGE_LO_BIT]} != TSI_EDGE_OFF);
        end
    end

    assign o_global_irq_enable = ge_q;
    assign o_pin_irq_enable = pe_q;
    assign o_timer_irq_enable = te_q;
    assign o_pin_irq_flag = pf_q;
    assign o_timer_irq_flag = tf_q;
    assign o_stack_ptr = sp_q;
    assign o_stack_full = full;

    // entry, priority and phase checks
    no_take_off_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        !ge_q |=> !o_vector_load
    ) else $error("vector taken while global enable low");

    ge_clear_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        o_vector_load |-> !ge_q
    ) else $error("global enable not cleared on entry");

    full_block_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        $past(full) |-> !o_vector_load
    ) else $error("interrupt taken with full stack");

    pin_prio_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (take && pin_req) |=> (o_vector_pc == TSI_PIN_VECTOR)
    ) else $error("external source lost priority");

    timer_win_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (take && !pin_req) |-> tmr_req
    ) else $error("timer taken without a timer request");

    timer_vec_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (take && !pin_req) |=> (o_vector_pc == TSI_TIMER_VECTOR) &&
            (!tf_q || $past(tmr_set))
    ) else $error("timer vector or flag wrong");

    phase_only_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        o_vector_load |-> $past(phase)
    ) else $error("service outside phase pulse");

    phase_rate_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        phase |=> !phase
    ) else $error("phase pulse longer than one cycle");

    vec_hold_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        !o_vector_load |-> $stable(o_vector_pc)
    ) else $error("vector address moved without a load");

    // request flag checks
    flag_hold_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (pf_q && !take && !i_pin_flag_clr) |=> pf_q
    ) else $error("pin flag dropped without cause");

    tmr_hold_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (tf_q && (win != TSI_SRC_TIMER) && !i_timer_flag_clr) |=> tf_q
    ) else $error("timer flag dropped without cause");

    pin_set_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        pin_set |=> pf_q
    ) else $error("pin event did not set its flag");

    timer_set_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        i_timer_ovf |=> tf_q
    ) else $error("overflow did not set timer flag");

    pin_clear_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        ((win == TSI_SRC_PIN) && !pin_set) |=> !pf_q
    ) else $error("pin flag not cleared on entry");

    tmr_clear_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        ((win == TSI_SRC_TIMER) && !tmr_set) |=> !tf_q
    ) else $error("timer flag not cleared on entry");

    // stack checks
    push_sp_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        take |=> (sp_q == $past(sp_q) + 3'h1)
    ) else $error("stack pointer not advanced on entry");

    saved_pc_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        take |=> (stack_q[$past(sp_q[1:0])] == $past(i_next_pc))
    ) else $error("next pc not saved on entry");

    ret_pop_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (pop && !push) |=> o_return_load && (sp_q == $past(sp_q) - 3'h1)
    ) else $error("return did not pop the stack");

    sp_bound_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        sp_q <= TSI_STACK_DEPTH
    ) else $error("stack pointer beyond stack depth");

    full_stay_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (full && !pop) |=> full
    ) else $error("full stack left without a pop");

    // wake and pass-through checks
    wake_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_halted && (pin_set || tmr_set)) |=> o_wake
    ) else $error("event while halted gave no wake");

    run_bit_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        1'b1 |=> (o_timer_run == $past(i_timer_control_reg[4]))
    ) else $error("timer run does not follow its control bit");

    pullhigh_a: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        1'b1 |=> (o_pullhigh == $past(i_pullhigh_en))
    ) else $error("pull-high request not kept");
endmodule : tsi_irq_unit

// [bench/tsi_seq_model.sv]
// program sequencer model that follows vector and return loads
`timescale 1ns/10ps
module tsi_seq_model
    import tsi_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_vector_load,
    input wire logic [TSI_PC_W-1:0] i_vector_pc,
    input wire logic i_return_load,
    input wire logic [TSI_PC_W-1:0] i_return_pc,
    input wire logic i_ret_req,
    output logic o_ret_pop,
    output logic [TSI_PC_W-1:0] o_next_pc
);
    logic [TSI_PC_W-1:0] pc_q;
    assign o_next_pc = pc_q + 11'h001;
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_q <= 11'h020;
            o_ret_pop <= 1'b0;
        end else begin
            o_ret_pop <= i_ret_req; // routine ends in a return, no calls
            if (i_vector_load)
                pc_q <= i_vector_pc;
            else if (i_return_load)
                pc_q <= i_return_pc;
        end
    end
endmodule : tsi_seq_model

// [bench/two_source_interrupt_unit_tb.sv]
// scenario testbench for the two-source interrupt unit
`timescale 1ns/10ps
module two_source_interrupt_unit_tb
    import tsi_pkg::*;
;
    logic clk = 0, rstn = 0, pin = 0, halt = 0, rreq = 0, pe = 0, te = 0;
    logic [9:0] p = '0;
    logic [7:0] misc = 8'h00, tcr = 8'h00;
    logic vl, rl, rpop, ge, pf, tf, full, wake, run, ph, pie, tie, pii;
    logic [10:0] vpc, rpc, npc;
    logic [2:0] sp;
    int n_errors = 0, n_compared = 0;
    always #4 clk = ~clk;
    tsi_irq_unit uut (.i_core_clk(clk), .i_rstn(rstn), .i_pin(pin),
        .i_timer_ovf(p[6]), .i_misc_control_reg(misc),
        .i_timer_control_reg(tcr), .i_port_direction_reg(8'h08),
        .i_pullhigh_en(1'b1), .i_global_set(p[0]), .i_global_clr(p[1]),
        .i_pin_en_wr(p[8]), .i_pin_en_val(pe), .i_timer_en_wr(p[9]),
        .i_timer_en_val(te), .i_pin_flag_clr(p[5]), .i_timer_flag_clr(p[4]),
        .i_pin_flag_set(p[3]), .i_timer_flag_set(p[2]), .i_call_push(p[7]),
        .i_ret_pop(rpop), .i_halted(halt), .i_next_pc(npc),
        .o_global_irq_enable(ge), .o_pin_irq_enable(pie),
        .o_timer_irq_enable(tie),
        .o_pin_irq_flag(pf), .o_timer_irq_flag(tf), .o_vector_load(vl),
        .o_vector_pc(vpc), .o_return_load(rl), .o_return_pc(rpc),
        .o_stack_ptr(sp), .o_stack_full(full), .o_wake(wake),
        .o_timer_run(run), .o_pullhigh(ph), .o_pin_is_irq(pii));
    tsi_seq_model partner (.i_core_clk(clk), .i_rstn(rstn),
        .i_vector_load(vl), .i_vector_pc(vpc), .i_return_load(rl),
        .i_return_pc(rpc), .i_ret_req(rreq), .o_ret_pop(rpop),
        .o_next_pc(npc));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(input int b);
        @(negedge clk) p[b] = 1'b1;
        @(negedge clk) p[b] = 1'b0;
    endtask : pulse
    task automatic setup(input logic pin_en, input logic tim_en);
        @(negedge clk) rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        pe = pin_en;
        te = tim_en;
        pulse(8);
        pulse(9);
    endtask : setup
    task automatic wait_vec(input logic [10:0] exp);
        int i;
        for (i = 0; i < 40 && vl !== 1'b1; i++) @(negedge clk);
        if (i == 40) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, vl, 1'b1);
            final_report();
        end else begin
            chk(vpc, exp);
        end
    endtask : wait_vec
    task automatic no_vec();
        repeat (20) @(negedge clk) chk(vl, 0); // held off
    endtask : no_vec
    task automatic t_timer();
        setup(0, 1);
        pulse(0);
        pulse(6);
        wait_vec(TSI_TIMER_VECTOR);
        @(negedge clk) chk({ge, tf, sp}, 16'h0001);
        @(negedge clk) rreq = 1'b1;
        @(negedge clk) rreq = 1'b0;
        @(negedge clk) chk({rl,rpc,sp}, {1'b1,11'h021,3'h0});
        $display("test timer take done");
    endtask : t_timer
    task automatic t_blocked();
        setup(0, 1);
        pulse(6);
        no_vec();
        te = 1'b0;
        pulse(9);
        chk(tf, 1);
        chk(tie, 0);
        pulse(4);
        @(negedge clk) chk(tf, 0);
        $display("test blocked done");
    endtask : t_blocked
    task automatic t_prio();
        setup(1, 1);
        pulse(3);
        pulse(2);
        pulse(0);
        wait_vec(TSI_PIN_VECTOR);
        @(negedge clk) chk({pf, tf, ge}, 16'h0002);
        $display("test priority done");
    endtask : t_prio
    task automatic t_edges();
        for (int e = 0; e < 4; e++) begin
            setup(1, 0);
            misc = {e[1:0], 6'h00};
            repeat (3) @(negedge clk);
            chk({pie, pii}, {1'b1, (e != 0)});
            pin = 1'b1;
            repeat (6) @(negedge clk);
            chk(pf, e[0]);
            pulse(5);
            pin = 1'b0;
            repeat (6) @(negedge clk);
            chk(pf, e[1]);
        end
        $display("test edge modes done");
    endtask : t_edges
    task automatic t_full();
        setup(0, 1);
        repeat (5) pulse(7);
        chk({full, sp}, 16'h000C);
        pulse(2);
        pulse(0);
        no_vec();
        @(negedge clk) rreq = 1'b1;
        @(negedge clk) rreq = 1'b0;
        wait_vec(TSI_TIMER_VECTOR);
        $display("test stack full done");
    endtask : t_full
    task automatic t_misc();
        int i;
        setup(0, 0);
        halt = 1'b1;
        tcr = 8'h10;
        pulse(6);
        for (i = 0; i < 4 && wake !== 1'b1; i++) @(negedge clk);
        chk(wake, 1);
        pulse(3);
        chk(wake, 1);
        chk({run, ph}, 16'h0003);
        halt = 1'b0;
        tcr = 8'h00;
        repeat (2) @(negedge clk);
        chk(run, 0);
        $display("test wake and pins done");
    endtask : t_misc
    initial begin
        repeat (3) @(negedge clk);
        t_timer();
        t_blocked();
        t_prio();
        t_edges();
        t_full();
        t_misc();
        final_report();
    end
endmodule : two_source_interrupt_unit_tb
